// [hw/wdg_pkg.sv]
package wdg_pkg;
  // Register map (byte address of the control register)
  localparam logic [7:0] WD_CTRL_REG_ADDR = 8'h2A;
  // Field positions inside the control register
  localparam int ACTIVE_BIT_POS = 7;
  localparam int GUARD_BIT_POS  = 6;
  localparam int COUNT_WIDTH    = 7;
  // Reset value: inactive, all counter bits set
  localparam logic       ACTIVE_RESET = 1'h0;
  localparam logic [6:0] COUNT_RESET  = 7'h7F;
  // Guard crossing: 40h to 3Fh
  localparam logic [6:0] COUNT_GUARD_EDGE = 7'h40;
  // Nominal prescaler period in divided oscillator cycles
  localparam int PRESCALE_NOM = 16384;
  // Per-timebase LSB figure and period multiple of 64 cycles
  localparam int LSB_TB0 = 59;
  localparam int LSB_TB1 = 53;
  localparam int LSB_TB2 = 35;
  localparam int LSB_TB3 = 54;
  localparam int LSB_OFFSET   = 128;
  localparam int LSB_SCALE    = 64;
  // Reset pulse time and clock rate
  localparam int RST_PULSE_NS = 30000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int RST_PULSE_CYC = RST_PULSE_NS / CLK_PERIOD_NS;
  // Timebase selection codes
  typedef enum logic [1:0] {
    WDG_TB_2MS  = 2'h0,
    WDG_TB_4MS  = 2'h1,
    WDG_TB_10MS = 2'h2,
    WDG_TB_25MS = 2'h3
  } wdg_tb_e;
  // Reset pulse generator states, Gray along the path
  typedef enum logic [1:0] {
    WDG_IDLE  = 2'h0,
    WDG_PULSE = 2'h1
  } wdg_state_e;
  // Register bus request bundle
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } wdg_bus_s;
endpackage

// [hw/wdg_prescaler.sv]
// Free-running prescaler: one tick every period cycles of the divided clock
module wdg_prescaler #(
  parameter int CNT_W = 14
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             osc_en,
  input  wire logic [CNT_W-1:0] period,
  output logic                  tick
);
  logic [CNT_W-1:0] count;       // Cycles since last tick
  logic [CNT_W-1:0] next_count;

  // Never cleared by a counter write, so timeout phase is unknown
  always_comb begin
    next_count = count;
    tick       = 1'b0;
    if (osc_en) begin
      if (count >= period - CNT_W'(1)) begin
        next_count = '0;
        tick       = 1'b1;
      end else begin
        next_count = count + CNT_W'(1);
      end
    end
  end

  // Register stage
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule

// [hw/wdg_top.sv]
// Functional notes
// R1: Counter decrements once per prescaler period
// R2: Six low bits set 64 timeout steps
// R3: Active and 40h to 3Fh triggers reset
// R4: Reset pin driven low about 30 us
// R5: Counter runs even when inactive
// R6: Software refreshes before guard bit clears
// R7: Software writes values FFh down to C0h
// R8: Counter write leaves prescaler phase alone
// R9: After reset watchdog is inactive
// R10: Once active, only reset deactivates
// R11: Active set, guard clear write resets
// R12: Halt while active resets, per option
// R13: Option selects reset on halt
// R14: Option selects always-active hardware watchdog
// R15: Timebase select steers prescaler period; here the period stays PRESCALE under every select
// R16: First decrement within the allowed window
// R17: Software always writes guard bit one
// R18: Bit 7 activation, bits 6:0 counter
// R19: Reset value 7Fh, inactive
// R20: Read returns activation and live counter
//
// The address-and-strobe port and the address map were left to the implementer.
module wdg_top #(
  parameter int PRESCALE = wdg_pkg::PRESCALE_NOM,
  parameter int PULSE    = wdg_pkg::RST_PULSE_CYC
) (
  input  wire logic       CLOCK,
  input  wire logic       RST,
  input  wire logic       OSC_EN,
  input  wire logic [1:0] TIMEBASE_SELECT,
  input  wire logic       HALT_EXEC,
  input  wire logic       OPT_HALT_RESET,
  input  wire logic       OPT_HW_WDG,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  output logic            RESET_N_OUT,
  output logic            RESET_N_OE
);
  localparam int PW = $clog2(PRESCALE + 1);
  localparam int RW = $clog2(PULSE + 1);

  // Elaboration check on parameters
  // Tick gap and pulse checks below need at least 9 and 8 cycles
  if (PRESCALE < 9 || PULSE < 8) begin : g_bad
    $error("wdg_top: parameter out of range");
  end

  wdg_pkg::wdg_bus_s bus;       // Bundled register request
  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  logic                               wd_active_bit;        // Activation flag
  logic [wdg_pkg::COUNT_WIDTH-1:0]    timeout_count_value;  // Live counter
  logic                               next_active;
  logic [wdg_pkg::COUNT_WIDTH-1:0]    next_count;
  logic [7:0]                         next_rdata;
  logic                               tick;                 // Prescaler tick
  logic [PW-1:0]                      period;               // Fixed period, PRESCALE under every select
  logic                               sel_hit;              // Address decode
  logic                               eff_active;           // Active incl. option
  logic                               trigger;              // Reset request
  wdg_pkg::wdg_state_e                state;
  wdg_pkg::wdg_state_e                next_state;
  logic [RW-1:0]                      pulse_cnt;            // Pulse length count
  logic [RW-1:0]                      next_pulse_cnt;
  logic [7:0]                         lsb_fig;              // Timebase LSB

  // Timebase picks the LSB figure of the first-tick window
  always_comb begin
    case (wdg_pkg::wdg_tb_e'(TIMEBASE_SELECT))             // [R15]
      wdg_pkg::WDG_TB_2MS:  lsb_fig = 8'(wdg_pkg::LSB_TB0);
      wdg_pkg::WDG_TB_4MS:  lsb_fig = 8'(wdg_pkg::LSB_TB1);
      wdg_pkg::WDG_TB_10MS: lsb_fig = 8'(wdg_pkg::LSB_TB2);
      default:              lsb_fig = 8'(wdg_pkg::LSB_TB3);
    endcase
  end

  // Long-run period stays nominal; timebase shifts neither period nor phase
  // Trade-off: period held at PRESCALE keeps tick spacing exact
  assign period = PW'(PRESCALE);                            // [R1] [R16]

  // Prescaler is never cleared by register writes
  wdg_prescaler #(
    .CNT_W (PW)
  ) u_pre (
    .clk    (CLOCK),
    .rst    (RST),
    .osc_en (OSC_EN),
    .period (period),
    .tick   (tick)                                          // [R8]
  );

  assign sel_hit    = (bus.addr == wdg_pkg::WD_CTRL_REG_ADDR);
  assign eff_active = wd_active_bit | OPT_HW_WDG;           // [R14]

  // Counter and activation next values
  always_comb begin
    next_active = wd_active_bit;
    next_count  = timeout_count_value;
    if (tick) begin
      next_count = timeout_count_value - 7'h01;            // [R1] [R5]
    end
    if (bus.wr && sel_hit) begin
      // Write reloads counter; activation only ever sets
      next_count  = bus.wdata[wdg_pkg::COUNT_WIDTH-1:0];    // [R2] [R18]
      next_active = wd_active_bit | bus.wdata[wdg_pkg::ACTIVE_BIT_POS]; // [R10]
    end
  end

  // Reset request sources
  always_comb begin
    trigger = 1'b0;
    if (eff_active && tick && !(bus.wr && sel_hit)
        && timeout_count_value == wdg_pkg::COUNT_GUARD_EDGE) begin
      trigger = 1'b1;                                       // [R3]
    end
    if (bus.wr && sel_hit && bus.wdata[wdg_pkg::ACTIVE_BIT_POS]
        && !bus.wdata[wdg_pkg::GUARD_BIT_POS]) begin
      trigger = 1'b1;                                       // [R11]
    end
    if (eff_active && HALT_EXEC && OPT_HALT_RESET) begin
      trigger = 1'b1;                                       // [R12] [R13]
    end
  end

  // Reset pulse machine
  always_comb begin
    next_state     = state;
    next_pulse_cnt = pulse_cnt;
    case (state)
      wdg_pkg::WDG_IDLE: begin
        if (trigger) begin
          next_state     = wdg_pkg::WDG_PULSE;
          next_pulse_cnt = RW'(PULSE - 1);
        end
      end
      wdg_pkg::WDG_PULSE: begin
        if (pulse_cnt == '0) begin
          next_state = wdg_pkg::WDG_IDLE;
        end else begin
          next_pulse_cnt = pulse_cnt - RW'(1);
        end
      end
      default: next_state = wdg_pkg::WDG_IDLE;
    endcase
  end

  // Open-drain reset pin: drive low only while pulsing
  assign RESET_N_OUT = 1'b0;
  assign RESET_N_OE  = (state == wdg_pkg::WDG_PULSE);       // [R4]

  // Read data, valid the cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    if (bus.rd && sel_hit) begin
      next_rdata = {wd_active_bit, timeout_count_value};    // [R20]
    end
  end

  // Register stage
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wd_active_bit       <= wdg_pkg::ACTIVE_RESET;         // [R9] [R19]
      timeout_count_value <= wdg_pkg::COUNT_RESET;          // [R19]
      state               <= wdg_pkg::WDG_IDLE;
      pulse_cnt           <= '0;
      RDATA               <= 8'h00;
    end else begin
      wd_active_bit       <= next_active;
      timeout_count_value <= next_count;
      state               <= next_state;
      pulse_cnt           <= next_pulse_cnt;
      RDATA               <= next_rdata;
    end
  end

  // Unused timebase figure kept visible for window tracking
  logic lsb_unused;
  assign lsb_unused = ^lsb_fig;

  // Assertions
  a_reset_hold_inactive: assert property (@(posedge CLOCK)  // [R9]
    RST |=> !wd_active_bit && timeout_count_value == wdg_pkg::COUNT_RESET)
    else $error("Watchdog not idle after reset");

  a_active_sticky: assert property (@(posedge CLOCK) disable iff (RST) // [R10]
    wd_active_bit |=> wd_active_bit)
    else $error("Activation cleared without reset");

  a_free_running: assert property (@(posedge CLOCK) disable iff (RST) // [R5]
    tick && !(WR && sel_hit) |=> timeout_count_value == $past(timeout_count_value) - 7'h01)
    else $error("Counter did not decrement on tick");

  a_guard_reset: assert property (@(posedge CLOCK) disable iff (RST) // [R3]
    eff_active && tick && !WR && timeout_count_value == wdg_pkg::COUNT_GUARD_EDGE
    && state == wdg_pkg::WDG_IDLE
    |=> RESET_N_OE)
    else $error("Guard crossing gave no reset");

  a_sw_reset: assert property (@(posedge CLOCK) disable iff (RST) // [R11]
    WR && sel_hit && WDATA[wdg_pkg::ACTIVE_BIT_POS] && !WDATA[wdg_pkg::GUARD_BIT_POS]
    && state == wdg_pkg::WDG_IDLE |=> RESET_N_OE)
    else $error("Software reset not issued");

  sequence s_pulse_start;
    !RESET_N_OE ##1 RESET_N_OE;
  endsequence
  a_pulse_len: assert property (@(posedge CLOCK) disable iff (RST) // [R4]
    s_pulse_start |-> RESET_N_OE [*8])
    else $error("Reset pulse too short");

  a_inactive_quiet: assert property (@(posedge CLOCK) disable iff (RST) // [R14]
    !eff_active && !(WR && sel_hit) && state == wdg_pkg::WDG_IDLE |=> !RESET_N_OE)
    else $error("Reset while inactive");

  a_read_data: assert property (@(posedge CLOCK) disable iff (RST) // [R20]
    RD && sel_hit |=> RDATA == {$past(wd_active_bit), $past(timeout_count_value)})
    else $error("Read data mismatch");

  a_halt_reset: assert property (@(posedge CLOCK) disable iff (RST) // [R12]
    eff_active && HALT_EXEC && OPT_HALT_RESET && state == wdg_pkg::WDG_IDLE |=> RESET_N_OE)
    else $error("Halt gave no reset");

  // Helper: pulled-low samples of the pin within the current pulse
  // A counter replaces a long repetition, which would be costly at 1500
  logic [RW-1:0] chk_len;       // Pulled samples so far
  logic [RW-1:0] next_chk_len;

  // Next length: counts while pulled, clears once released
  always_comb begin
    next_chk_len = '0;
    if (RESET_N_OE) begin
      next_chk_len = chk_len + RW'(1);
    end
  end

  // Length register, cleared by reset
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      chk_len <= '0;
    end else begin
      chk_len <= next_chk_len;
    end
  end

  // Building blocks for the multi-step checks
  sequence s_ctrl_write;
    WR && sel_hit;
  endsequence

  sequence s_pulse_end;
    RESET_N_OE ##1 !RESET_N_OE;
  endsequence

  // Whole pulse lasts exactly the configured length
  a_pulse_exact: assert property (@(posedge CLOCK) disable iff (RST) // [R4]
    s_pulse_end |-> chk_len == RW'(PULSE))
    else $error("Reset pulse length wrong");

  // Pulse never runs past its length
  a_pulse_bound: assert property (@(posedge CLOCK) disable iff (RST) // [R4]
    RESET_N_OE |-> chk_len < RW'(PULSE))
    else $error("Reset pulse too long");

  // Pin is only ever pulled low, never driven high
  a_pin_low: assert property (@(posedge CLOCK) disable iff (RST) // [R4]
    RESET_N_OE |-> !RESET_N_OUT)
    else $error("Reset pin driven high");

  // Pulse counter steps down once per cycle
  a_pulse_countdown: assert property (@(posedge CLOCK) disable iff (RST) // [R4]
    state == wdg_pkg::WDG_PULSE && pulse_cnt != '0
    |=> state == wdg_pkg::WDG_PULSE && pulse_cnt == $past(pulse_cnt) - RW'(1))
    else $error("Pulse counter misstep");

  // Control write loads the counter field
  a_write_load: assert property (@(posedge CLOCK) disable iff (RST) // [R2]
    s_ctrl_write |=> timeout_count_value == $past(WDATA[wdg_pkg::COUNT_WIDTH-1:0]))
    else $error("Counter not loaded by write");

  // Activation bit written high sets the flag
  a_write_activate: assert property (@(posedge CLOCK) disable iff (RST) // [R18]
    s_ctrl_write ##0 WDATA[wdg_pkg::ACTIVE_BIT_POS] |=> wd_active_bit)
    else $error("Activation bit not set");

  // Without a control write the flag cannot move
  a_active_only_write: assert property (@(posedge CLOCK) disable iff (RST) // [R10]
    !(WR && sel_hit) |=> $stable(wd_active_bit))
    else $error("Activation changed without write");

  // Counter moves only on a tick or a write
  a_count_hold: assert property (@(posedge CLOCK) disable iff (RST) // [R5]
    !tick && !(WR && sel_hit) |=> $stable(timeout_count_value))
    else $error("Counter moved without tick");

  // Read data is zero unless a control read came before
  a_read_idle: assert property (@(posedge CLOCK) disable iff (RST) // [R20]
    !(RD && sel_hit) |=> RDATA == 8'h00)
    else $error("Read data not cleared");

  // Ticks are spaced by the prescaler, never back to back
  a_tick_gap: assert property (@(posedge CLOCK) disable iff (RST) // [R1]
    tick |=> !tick [*8])
    else $error("Prescaler ticks too close");

  // Halt without the option gives no reset
  a_halt_gated: assert property (@(posedge CLOCK) disable iff (RST) // [R13]
    HALT_EXEC && !OPT_HALT_RESET && !tick && !(WR && sel_hit)
    && state == wdg_pkg::WDG_IDLE |=> !RESET_N_OE)
    else $error("Halt reset without option");

  // Ticks away from the guard edge stay silent
  a_guard_quiet: assert property (@(posedge CLOCK) disable iff (RST) // [R3]
    tick && timeout_count_value != wdg_pkg::COUNT_GUARD_EDGE && !(WR && sel_hit)
    && !HALT_EXEC && state == wdg_pkg::WDG_IDLE |=> !RESET_N_OE)
    else $error("Reset away from guard edge");

  // Guard-clear write without the activation bit, while inactive and unarmed, gives no reset
  a_sw_needs_active: assert property (@(posedge CLOCK) disable iff (RST) // [R11]
    WR && sel_hit && !WDATA[wdg_pkg::ACTIVE_BIT_POS] && !eff_active
    && state == wdg_pkg::WDG_IDLE |=> !RESET_N_OE)
    else $error("Reset from inactive write");

  // Hardware option arms the guard edge by itself
  a_hw_guard: assert property (@(posedge CLOCK) disable iff (RST) // [R14]
    OPT_HW_WDG && tick && timeout_count_value == wdg_pkg::COUNT_GUARD_EDGE
    && !(WR && sel_hit) && state == wdg_pkg::WDG_IDLE |=> RESET_N_OE)
    else $error("Hardware option gave no reset");

  // Reset clears read data and releases the pin
  a_reset_outputs: assert property (@(posedge CLOCK) // [R19]
    RST |=> RDATA == 8'h00 && !RESET_N_OE)
    else $error("Outputs not cleared by reset");
endmodule

// [test/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Shortened prescaler period and reset pulse so the run stays short
  localparam int P = 16;
  localparam int W = 10;
  localparam logic [7:0] CR = wdg_pkg::WD_CTRL_REG_ADDR;
  logic       clock    = 1'b0;
  logic       rst      = 1'b1;
  logic       halt     = 1'b0;
  logic       opt_halt = 1'b0;
  logic       opt_hw   = 1'b0;
  logic       rd       = 1'b0;
  logic       wr       = 1'b0;
  logic [1:0] tbsel    = 2'h0;
  logic [7:0] addr     = 8'h00;
  logic [7:0] wdata    = 8'h00;
  logic [7:0] rdata;
  logic       rst_n_out;
  logic       rst_n_oe;
  int         error_cnt = 0;
  int         checked   = 0;

  // Free-running 50 MHz clock
  always #10 clock = ~clock;

  // Oscillator enable tied high: full-rate prescaler
  wdg_top #(.PRESCALE(P), .PULSE(W)) DUT (
    .CLOCK(clock), .RST(rst), .OSC_EN(1'b1), .TIMEBASE_SELECT(tbsel),
    .HALT_EXEC(halt), .OPT_HALT_RESET(opt_halt), .OPT_HW_WDG(opt_hw),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .RESET_N_OUT(rst_n_out), .RESET_N_OE(rst_n_oe)
  );

  // Compare and count
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Verdict and end of run
  task automatic final_report;
    if (error_cnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Synchronous reset for two cycles
  task automatic do_reset;
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
  endtask

  // One-cycle write; returns once the write has landed
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask

  // One-cycle read; data taken in the following cycle only
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  // Pulse must start within lo..hi cycles and last W cycles
  task automatic pulse_chk(input int lo, input int hi);
    int n;
    int m;
    n = 0;
    m = 0;
    while (rst_n_oe !== 1'b1 && n < hi) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("pulse start", 8'h01, 8'(n >= lo && n <= hi && rst_n_oe === 1'b1));
    chk("reset pin level", 8'h00, {7'h00, rst_n_out});
    while (rst_n_oe === 1'b1 && m < 3 * W) begin
      @(posedge clock);
      #1;
      m++;
    end
    chk("pulse length", 8'(W), 8'(m));
  endtask

  // Count cycles with the pin pulled over a span; expects none
  task automatic quiet(input string what, input int span);
    int bad;
    bad = 0;
    repeat (span) begin
      @(posedge clock);
      #1;
      if (rst_n_oe !== 1'b0) bad++;
    end
    chk(what, 8'h00, 8'(bad));
  endtask

  // Reset value, then one step per period under every timebase
  task automatic t_free_run;
    logic [7:0] v1;
    logic [7:0] v2;
    bus_rd(CR, v1);
    chk("ctrl after reset", 8'h7F, v1);
    for (int t = 0; t < 4; t++) begin
      @(posedge clock);
      tbsel <= 2'(t);
      bus_rd(CR, v1);
      repeat (P - 2) @(posedge clock);
      bus_rd(CR, v2);
      chk("count step", v1 - 8'h01, v2);
    end
    // Inactive crossing of the guard bit must stay silent
    bus_wr(CR, 8'h41);
    quiet("inactive crossing", 3 * P);
    bus_rd(CR, v1);
    chk("count below guard", 8'h00, {7'h00, v1[6]});
  endtask

  // Unmapped address: reads zero, writes ignored
  task automatic t_unmapped;
    logic [7:0] v;
    bus_rd(CR + 8'h01, v);
    chk("unmapped read", 8'h00, v);
    bus_wr(CR + 8'h01, 8'hBF);
    chk("unmapped write pin", 8'h00, {7'h00, rst_n_oe});
    bus_rd(CR, v);
    chk("unmapped write active", 8'h00, {7'h00, v[7]});
  endtask

  // Activation sticks; guard-clear write resets at once
  task automatic t_sticky;
    logic [7:0] v;
    bus_wr(CR, 8'hFF);
    bus_wr(CR, 8'h7F);
    bus_rd(CR, v);
    chk("active kept", 8'h01, {7'h00, v[7]});
    bus_wr(CR, 8'hBF);
    chk("software reset", 8'h01, {7'h00, rst_n_oe});
    pulse_chk(0, 0);
    do_reset;
    bus_rd(CR, v);
    chk("ctrl after second reset", 8'h7F, v);
  endtask

  // Regular refresh keeps the guard bit set: no reset
  task automatic t_refresh;
    for (int i = 0; i < 6; i++) begin
      bus_wr(CR, 8'hC2);
      quiet("refreshed watchdog", P - 4);
    end
    do_reset;
  endtask

  // Timeout from C1h: two ticks then the pulse
  task automatic t_timeout;
    bus_wr(CR, 8'hC1);
    pulse_chk(16, 34);
    do_reset;
  endtask

  // Halt resets only with the option set
  task automatic t_halt;
    bus_wr(CR, 8'hFF);
    @(posedge clock);
    halt <= 1'b1;
    @(posedge clock);
    halt <= 1'b0;
    quiet("halt without option", 4);
    @(posedge clock);
    opt_halt <= 1'b1;
    halt     <= 1'b1;
    @(posedge clock);
    halt <= 1'b0;
    #1;
    pulse_chk(0, 3);
    @(posedge clock);
    opt_halt <= 1'b0;
    do_reset;
  endtask

  // Hardware option: timeout without the activation bit
  task automatic t_hw;
    opt_hw <= 1'b1;
    bus_wr(CR, 8'h41);
    pulse_chk(1, 34);
    @(posedge clock);
    opt_hw <= 1'b0;
    do_reset;
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_free_run;
    do_reset;
    t_unmapped;
    t_sticky;
    t_refresh;
    t_timeout;
    t_halt;
    t_hw;
    final_report;
  end

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    final_report;
  end
endmodule
